// file: inc/bpd_defines.vh
`ifndef BPD_DEFINES_VH
`define BPD_DEFINES_VH
// ==========================================
// Register addresses (6-bit link address)
`define BPD_ADDR_W 6
`define BPD_ADDR_CFG 6'h03
`define BPD_ADDR_OC 6'h10
`define BPD_ADDR_ULD 6'h11
`define BPD_ADDR_SUP 6'h12
// ==========================================
// Field layout
`define BPD_CFG_RESET 16'h0000
`define BPD_CFG_WMASK 16'h0037
`define BPD_RECOVERY_SPEED_SELECT_BIT 5
`define BPD_LATCH_BIT 4
`define BPD_IS_HI 2
`define BPD_IS_LO 0
`define BPD_IS_OUT1 3'h3
`define BPD_IS_OUT2 3'h4
`define BPD_STG_HI 9
`define BPD_STG_LO 6
`define BPD_SUPPLY_UNDERVOLTAGE_FLAG_BIT 3
`define BPD_VSOV_BIT 2
`define BPD_GSB_FAULT 7
`define BPD_GSB_ULD 6
// ==========================================
// Serial frame layout
`define BPD_FRAME_BITS 5'd24
`define BPD_HDR_LAST 5'd7
`define BPD_HDR_WR 7
`define BPD_HDR_RC 6
`define BPD_CNT_MAX 5'd31
// ==========================================
// Synchroniser bundle: sclk, cs_n, mosi, pin, ov, uv, oc[3:0], under[3:0]
`define BPD_SYNC_W 14
`define BPD_SYNC_RST 14'h1000
// Edge history of sclk and cs_n: {sclk, cs_n}
`define BPD_EDGE_RST 2'b01
// ==========================================
// Timing
`define BPD_CLK_MHZ 50
`define BPD_OCR_SLOW_US 1000
`define BPD_OCR_FAST_US 100
`define BPD_ULD_FILT_US 200
`define BPD_CNT_W 24
`endif

// file: logic/bpd_uld_filter.v
`timescale 1ns/100ps
`default_nettype none
`include "bpd_defines.vh"
module bpd_uld_filter #(
   parameter CNT_W = `BPD_CNT_W,
   parameter [CNT_W-1:0] FILT_CYC = 24'd10000
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire arst_n_i,
   // Stage state
   input wire stage_on_i,
   input wire under_i,
   // Event
   output wire uld_evt_o
);
   reg [CNT_W-1:0] cnt;
   reg fired;

   // ==========================================
   // Continuous low-current timer, fires once per episode
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= {CNT_W{1'b0}};
         fired <= 1'b0;
      end else if (!(stage_on_i && under_i)) begin
         cnt <= {CNT_W{1'b0}};
         fired <= 1'b0;
      end else if (cnt != FILT_CYC) begin
         cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
         fired <= 1'b1;
      end
   end

   assign uld_evt_o = stage_on_i && under_i && (cnt == FILT_CYC) && !fired;
endmodule // bpd_uld_filter
`default_nettype wire

// file: logic/bpd_protect_diag.v
`timescale 1ns/100ps
`default_nettype none
`include "bpd_defines.vh"
// Notes on behaviour
// [RULE1] Speed bit: 0 slow, 1 fast restart
// [RULE2] Latch bit 0: resume after supply fault
// [RULE3] Latch bit 1: host clears supply flag
// [RULE4] Sense code 011 out1, 100 out2
// [RULE5] Sense code turns shared pin into output
// [RULE6] Overcurrent sets stage flag, stage off
// [RULE7] Overcurrent also sets global fault summary
// [RULE8] Auto-restart re-enables after selected delay
// [RULE9] Else host clears flag, recommands stage
// [RULE10] Underload flag per stage, only while on
// [RULE11] Underload needs continuous filter time
// [RULE12] Underload also sets global underload bit
// [RULE13] Mask blocks global underload, not flags
// [RULE14] Supply fault disables all, sets flag
// [RULE15] Flags latched until read-and-clear; zeros
module bpd_protect_diag #(
   parameter integer OCR_SLOW_CYC = `BPD_OCR_SLOW_US * `BPD_CLK_MHZ,
   parameter integer OCR_FAST_CYC = `BPD_OCR_FAST_US * `BPD_CLK_MHZ,
   parameter integer ULD_FILT_CYC = `BPD_ULD_FILT_US * `BPD_CLK_MHZ
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire arst_n_i,
   // Serial link (host is master)
   input wire sclk_i,
   input wire cs_n_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_n_o,
   // Shared sense / second pulse pin
   input wire current_sense_pin_i,
   output reg current_sense_pin_oe_n_o,
   output reg [1:0] sense_route_o,
   output reg second_pulse_input_o,
   // Stage control, order HS1 LS1 HS2 LS2 (msb first)
   input wire [3:0] stage_cmd_i,
   input wire [3:0] overcurrent_autorestart_enable_i,
   input wire global_underload_mask_i,
   output reg [3:0] stage_en_o,
   // Analogue comparators
   input wire [3:0] oc_detect_i,
   input wire [3:0] under_detect_i,
   input wire supply_ov_i,
   input wire supply_uv_i,
   // Summary
   output reg global_fault_summary_o,
   output reg global_underload_o
);
   localparam [`BPD_CNT_W-1:0] SLOW_CNT = OCR_SLOW_CYC[`BPD_CNT_W-1:0];
   localparam [`BPD_CNT_W-1:0] FAST_CNT = OCR_FAST_CYC[`BPD_CNT_W-1:0];
   localparam [`BPD_CNT_W-1:0] FILT_CNT = ULD_FILT_CYC[`BPD_CNT_W-1:0];

   reg [`BPD_SYNC_W-1:0] s1, s2;
   reg [1:0] s3;
   reg [15:0] protection_config;
   reg [3:0] overcurrent_flag, underload_flag, oc_off;
   reg supply_undervoltage_flag, supply_overvoltage_flag;
   reg [`BPD_CNT_W-1:0] rst_cnt;
   reg [23:0] rx_sh;
   reg [23:0] tx_sh;
   reg [4:0] bit_cnt;
   reg [15:0] rd_snap;
   reg [7:0] hdr;
   reg [3:0] next_oc_flag, next_uld_flag, next_oc_off, oc_clr, uld_clr;
   reg next_uv, next_ov, uv_clr, ov_clr;
   wire [3:0] uld_evt;
   wire sclk_rise, sclk_fall, cs_fall, cs_rise, mosi_s, pin_s, ov_s, uv_s;
   wire [3:0] oc_s, under_s, oc_set, oc_free;
   wire [7:0] hdr_now;
   wire restart_done, supply_off, sense_on, frame_ok;
   wire [2:0] sense_select;

   function [15:0] rd_mux;
      input [`BPD_ADDR_W-1:0] addr;
      input [15:0] cfg;
      input [3:0] oc;
      input [3:0] uld;
      input uv;
      input ov;
      begin
         rd_mux = 16'h0000;
         case (addr)
            `BPD_ADDR_CFG: rd_mux = cfg & `BPD_CFG_WMASK;
            `BPD_ADDR_OC: rd_mux[`BPD_STG_HI:`BPD_STG_LO] = oc;
            `BPD_ADDR_ULD: rd_mux[`BPD_STG_HI:`BPD_STG_LO] = uld;
            `BPD_ADDR_SUP: begin
               rd_mux[`BPD_SUPPLY_UNDERVOLTAGE_FLAG_BIT] = uv;
               rd_mux[`BPD_VSOV_BIT] = ov;
            end
            default: rd_mux = 16'h0000;
         endcase
      end
   endfunction

   // ==========================================
   // Input synchronisers
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1 <= `BPD_SYNC_RST;
         s2 <= `BPD_SYNC_RST;
         s3 <= `BPD_EDGE_RST;
      end else begin
         s1 <= {sclk_i, cs_n_i, mosi_i, current_sense_pin_i, supply_ov_i, supply_uv_i,
                oc_detect_i, under_detect_i};
         s2 <= s1;
         s3 <= s2[13:12];
      end
   end

   assign sclk_rise = s2[13] && !s3[1] && !s2[12];
   assign sclk_fall = !s2[13] && s3[1] && !s2[12];
   assign cs_fall = !s2[12] && s3[0];
   assign cs_rise = s2[12] && !s3[0];
   assign mosi_s = s2[11];
   assign pin_s = s2[10];
   assign ov_s = s2[9];
   assign uv_s = s2[8];
   assign oc_s = s2[7:4];
   assign under_s = s2[3:0];
   assign hdr_now = {rx_sh[6:0], mosi_s};
   assign frame_ok = cs_rise && (bit_cnt == `BPD_FRAME_BITS);

   // ==========================================
   // Serial shifter, in-frame response
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_sh <= 24'h000000;
         tx_sh <= 24'h000000;
         bit_cnt <= 5'd0;
         rd_snap <= 16'h0000;
         hdr <= 8'h00;
         miso_o <= 1'b0;
         miso_oe_n_o <= 1'b1;
      end else begin
         miso_o <= tx_sh[23];
         miso_oe_n_o <= s2[12];
         if (cs_fall) begin
            bit_cnt <= 5'd0;
            tx_sh <= {global_fault_summary_o, global_underload_o, 6'h00, 16'h0000};
         end else if (sclk_rise) begin
            rx_sh <= {rx_sh[22:0], mosi_s};
            if (bit_cnt != `BPD_CNT_MAX)
               bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `BPD_HDR_LAST) begin
               hdr <= hdr_now;
               rd_snap <= rd_mux(hdr_now[`BPD_ADDR_W-1:0], protection_config,
                                 overcurrent_flag, underload_flag,
                                 supply_undervoltage_flag, supply_overvoltage_flag);
               tx_sh <= {tx_sh[23], rd_mux(hdr_now[`BPD_ADDR_W-1:0], protection_config,
                         overcurrent_flag, underload_flag, supply_undervoltage_flag,
                         supply_overvoltage_flag), 7'h00};
            end
         end else if (sclk_fall) begin
            tx_sh <= {tx_sh[22:0], 1'b0};
         end
      end
   end

   // ==========================================
   // Read-and-clear of the bits shown in the frame
   always @* begin
      oc_clr = 4'h0;
      uld_clr = 4'h0;
      uv_clr = 1'b0;
      ov_clr = 1'b0;
      if (frame_ok && hdr[`BPD_HDR_RC]) begin
         case (hdr[`BPD_ADDR_W-1:0])
            `BPD_ADDR_OC: oc_clr = rd_snap[`BPD_STG_HI:`BPD_STG_LO]; // [RULE15]
            `BPD_ADDR_ULD: uld_clr = rd_snap[`BPD_STG_HI:`BPD_STG_LO]; // [RULE15]
            `BPD_ADDR_SUP: begin
               uv_clr = rd_snap[`BPD_SUPPLY_UNDERVOLTAGE_FLAG_BIT]; // [RULE3]
               ov_clr = rd_snap[`BPD_VSOV_BIT]; // [RULE3]
            end
            default: oc_clr = 4'h0;
         endcase
      end
   end

   // ==========================================
   // Protection logic
   assign oc_set = oc_s & stage_en_o; // [RULE6]
   assign restart_done = rst_cnt ==
                         (protection_config[`BPD_RECOVERY_SPEED_SELECT_BIT] ? FAST_CNT : SLOW_CNT); // [RULE1]
   assign oc_free = (restart_done ? (oc_off & overcurrent_autorestart_enable_i) : 4'h0) // [RULE8]
                  | (~overcurrent_flag & ~stage_cmd_i & ~overcurrent_autorestart_enable_i); // [RULE9]
   assign supply_off = uv_s || ov_s || (protection_config[`BPD_LATCH_BIT] && // [RULE2]
                       (supply_undervoltage_flag || supply_overvoltage_flag)); // [RULE3]
   assign sense_select = protection_config[`BPD_IS_HI:`BPD_IS_LO];
   assign sense_on = (sense_select == `BPD_IS_OUT1) || (sense_select == `BPD_IS_OUT2); // [RULE4]

   always @* begin
      next_oc_flag = (overcurrent_flag & ~oc_clr) | oc_set; // [RULE6]
      next_uld_flag = (underload_flag & ~uld_clr) | uld_evt; // [RULE10]
      next_oc_off = (oc_off & ~oc_free) | oc_set;
      next_uv = (supply_undervoltage_flag && !uv_clr) || uv_s; // [RULE14]
      next_ov = (supply_overvoltage_flag && !ov_clr) || ov_s; // [RULE14]
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_uld
         bpd_uld_filter #(
            .CNT_W(`BPD_CNT_W),
            .FILT_CYC(FILT_CNT)
         ) u_filt (
            .clk_sys_i(clk_sys_i),
            .arst_n_i(arst_n_i),
            .stage_on_i(stage_en_o[g]), // [RULE10]
            .under_i(under_s[g]),
            .uld_evt_o(uld_evt[g]) // [RULE11]
         );
      end
   endgenerate

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         protection_config <= `BPD_CFG_RESET;
         overcurrent_flag <= 4'h0;
         underload_flag <= 4'h0;
         oc_off <= 4'h0;
         supply_undervoltage_flag <= 1'b0;
         supply_overvoltage_flag <= 1'b0;
         rst_cnt <= {`BPD_CNT_W{1'b0}};
         stage_en_o <= 4'h0;
         global_fault_summary_o <= 1'b0;
         global_underload_o <= 1'b0;
         sense_route_o <= 2'b00;
         current_sense_pin_oe_n_o <= 1'b1;
         second_pulse_input_o <= 1'b0;
      end else begin
         if (frame_ok && hdr[`BPD_HDR_WR] && (hdr[`BPD_ADDR_W-1:0] == `BPD_ADDR_CFG))
            protection_config <= rx_sh[15:0] & `BPD_CFG_WMASK; // [RULE15]
         overcurrent_flag <= next_oc_flag;
         underload_flag <= next_uld_flag;
         oc_off <= next_oc_off;
         supply_undervoltage_flag <= next_uv;
         supply_overvoltage_flag <= next_ov;
         if (!(|(oc_off & overcurrent_autorestart_enable_i)) || restart_done)
            rst_cnt <= {`BPD_CNT_W{1'b0}};
         else
            rst_cnt <= rst_cnt + {{(`BPD_CNT_W-1){1'b0}}, 1'b1}; // [RULE8]
         stage_en_o <= supply_off ? 4'h0 : (stage_cmd_i & ~next_oc_off); // [RULE14] [RULE6]
         global_fault_summary_o <= (|next_oc_flag) || next_uv || next_ov; // [RULE7]
         global_underload_o <= (|next_uld_flag) && !global_underload_mask_i; // [RULE12] [RULE13]
         sense_route_o <= {sense_select == `BPD_IS_OUT2, sense_select == `BPD_IS_OUT1}; // [RULE4]
         current_sense_pin_oe_n_o <= !sense_on; // [RULE5]
         second_pulse_input_o <= sense_on ? 1'b0 : pin_s; // [RULE5]
      end
   end
endmodule // bpd_protect_diag
`default_nettype wire

// file: verification/bpd_protect_diag_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks
module bpd_protect_diag_props (
   // Clock and reset
   input wire clk_sys_i,
   input wire arst_n_i,
   // Watched ports
   input wire current_sense_pin_oe_n_o,
   input wire [1:0] sense_route_o,
   input wire second_pulse_input_o,
   input wire [3:0] stage_cmd_i,
   input wire [3:0] stage_en_o,
   input wire [3:0] oc_detect_i,
   input wire supply_ov_i,
   input wire supply_uv_i,
   input wire global_underload_mask_i,
   input wire global_fault_summary_o,
   input wire global_underload_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_oc_hit;
      stage_en_o[3] && oc_detect_i[3];
   endsequence
   sequence s_supply_bad;
      (supply_ov_i || supply_uv_i) [*6];
   endsequence
   a_sense_route_on: assert property (!current_sense_pin_oe_n_o |->
      $onehot(sense_route_o))
      else $error("sense route not one-hot");
   a_sense_route_off: assert property (current_sense_pin_oe_n_o |->
      sense_route_o == 2'h0)
      else $error("sense route while pin is input");
   a_pulse_in_quiet: assert property (!current_sense_pin_oe_n_o |->
      !second_pulse_input_o)
      else $error("pulse input seen while pin drives");
   a_oc_stage_off: assert property (s_oc_hit |-> ##[1:6] !stage_en_o[3])
      else $error("stage stays on after overcurrent");
   a_oc_summary: assert property (s_oc_hit |-> ##[1:6] global_fault_summary_o)
      else $error("fault summary missing");
   a_supply_all_off: assert property (s_supply_bad |-> stage_en_o == 4'h0)
      else $error("stage on during supply fault");
   a_stage_needs_cmd: assert property ((stage_cmd_i == 4'h0) [*3] |->
      stage_en_o == 4'h0)
      else $error("stage on without command");
   a_uld_masked: assert property (global_underload_mask_i [*2] |-> !global_underload_o)
      else $error("global underload while masked");
endmodule // bpd_protect_diag_props
bind bpd_protect_diag bpd_protect_diag_props i_bpd_protect_diag_props (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
   .current_sense_pin_oe_n_o(current_sense_pin_oe_n_o), .sense_route_o(sense_route_o),
   .second_pulse_input_o(second_pulse_input_o), .stage_cmd_i(stage_cmd_i),
   .stage_en_o(stage_en_o), .oc_detect_i(oc_detect_i), .supply_ov_i(supply_ov_i),
   .supply_uv_i(supply_uv_i), .global_underload_mask_i(global_underload_mask_i),
   .global_fault_summary_o(global_fault_summary_o), .global_underload_o(global_underload_o));
`default_nettype wire

// file: verification/bpd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Serial master, clock idle low between frames
module bpd_host_model (
   // Serial link
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
      integer i;
      cs_n_o = 1'b0;
      for (i = 23; i >= 0; i--) begin
         mosi_o = tx[i];
         #80 sclk_o = 1'b1;
         #80 rx[i] = miso_i;
         sclk_o = 1'b0;
      end
      #80 cs_n_o = 1'b1;
      // Released data line toggles
      mosi_o = ~mosi_o;
      #120;
   endtask
endmodule // bpd_host_model
`default_nettype wire

// file: verification/bpd_protect_diag_bench.sv
`timescale 1ns/100ps
`default_nettype none
module bpd_protect_diag_bench;
   logic clk = 1'b0, arst_n, sclk, cs_n, mosi, miso, miso_oe_n, pin_in, pin_oe_n, pulse;
   logic mask, ov, uv, fsum, guld;
   logic [1:0] route;
   logic [2:0] c;
   logic [3:0] cmd, ocr, en, oc, under;
   logic [23:0] rx;
   wire miso_w;
   integer failures = 0, samples_checked = 0, i;
   assign miso_w = miso_oe_n ? 1'b1 : miso;
   always #10 clk = ~clk;
   bpd_protect_diag #(.OCR_SLOW_CYC(40), .OCR_FAST_CYC(10), .ULD_FILT_CYC(20))
   i_bpd_protect_diag (.clk_sys_i(clk), .arst_n_i(arst_n), .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n), .current_sense_pin_i(pin_in),
      .current_sense_pin_oe_n_o(pin_oe_n), .sense_route_o(route), .second_pulse_input_o(pulse),
      .stage_cmd_i(cmd), .overcurrent_autorestart_enable_i(ocr), .global_underload_mask_i(mask),
      .stage_en_o(en), .oc_detect_i(oc), .under_detect_i(under), .supply_ov_i(ov),
      .supply_uv_i(uv), .global_fault_summary_o(fsum), .global_underload_o(guld));
   bpd_host_model i_bpd_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [5:0] a, input logic [15:0] d);
      tick(1);
      i_bpd_host_model.xfer({2'b10, a, d}, rx);
   endtask
   task rd(input logic rc, input logic [5:0] a, input logic [15:0] exp);
      tick(1);
      i_bpd_host_model.xfer({1'b0, rc, a, 16'h0000}, rx);
      chk(rx[15:0], exp);
   endtask
   task pulse_oc;
      oc = 4'h8;
      tick(3);
      oc = 4'h0;
      tick(3);
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      give_verdict;
   end
   initial begin
      {arst_n, cmd, ocr, mask, oc, under, ov, uv} = '0;
      pin_in = 1'b1;
      tick(8);
      arst_n = 1'b1;
      tick(4);
      rd(0, 6'h03, 16'h0000);
      rd(0, 6'h10, 16'h0000);
      rd(0, 6'h11, 16'h0000);
      wr(6'h03, 16'hffff);
      rd(0, 6'h03, 16'h0037);
      rd(0, 6'h2a, 16'h0000);
      wr(6'h10, 16'h0000);
      rd(0, 6'h03, 16'h0037);
      for (i = 0; i < 8; i++) begin
         c = i[2:0];
         pin_in = c[0];
         wr(6'h03, {13'h0000, c});
         chk(pin_oe_n, !(c == 3'h3 || c == 3'h4));
         chk(route, {c == 3'h4, c == 3'h3});
         chk(pulse, c[0] && !(c == 3'h3 || c == 3'h4));
      end
      cmd = 4'hf;
      tick(4);
      chk(en, 4'hf);
      pulse_oc;
      chk(en, 4'h7);
      chk(fsum, 1'b1);
      rd(1, 6'h10, 16'h0200);
      chk(rx[23:16], 16'h0080);
      chk(en, 4'h7);
      cmd = 4'h7;
      tick(2);
      cmd = 4'hf;
      tick(4);
      chk(en, 4'hf);
      chk(fsum, 1'b0);
      ocr = 4'hf;
      for (i = 0; i < 2; i++) begin
         wr(6'h03, {10'h000, i[0], 5'h00});
         pulse_oc;
         chk(en, 4'h7);
         tick(24);
         chk(en, i ? 4'hf : 4'h7);
         tick(30);
         chk(en, 4'hf);
         rd(1, 6'h10, 16'h0200);
      end
      cmd = 4'he;
      under = 4'h1;
      tick(40);
      rd(0, 6'h11, 16'h0000);
      cmd = 4'hf;
      tick(10);
      under = 4'h0;
      tick(4);
      rd(0, 6'h11, 16'h0000);
      under = 4'h1;
      tick(30);
      under = 4'h0;
      tick(4);
      chk(guld, 1'b1);
      rd(1, 6'h11, 16'h0040);
      chk(rx[23:16], 16'h0040);
      chk(guld, 1'b0);
      mask = 1'b1;
      under = 4'h1;
      tick(30);
      under = 4'h0;
      chk(guld, 1'b0);
      rd(1, 6'h11, 16'h0040);
      mask = 1'b0;
      wr(6'h03, 16'h0000);
      uv = 1'b1;
      tick(6);
      chk(en, 4'h0);
      uv = 1'b0;
      tick(6);
      chk(en, 4'hf);
      rd(1, 6'h12, 16'h0008);
      wr(6'h03, 16'h0010);
      ov = 1'b1;
      tick(6);
      ov = 1'b0;
      tick(6);
      chk(en, 4'h0);
      rd(1, 6'h12, 16'h0004);
      chk(en, 4'hf);
      give_verdict;
   end
endmodule // bpd_protect_diag_bench
`default_nettype wire
